//--- bstap_ctl_model.sv
// far-side test controller driving three test pins (tck, tms, tdi) and reading tdo
`timescale 1ns/100ps
module bstap_ctl_model (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // test clock stands low between steps
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // one test clock: mode and data set up while low, tdo taken at the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #62.5 o_tck = 1'b1;
    tdo = i_tdo;
    #62.5 o_tck = 1'b0;
  endtask
endmodule

//--- bstap_pkg.sv
// package for the boundary-scan test access port block
// ==========================================
// Behaviour
// - supports extest, sample/preload and bypass instructions
// - reached only through four test pins
// - controller state held in four bits
// - transitions follow mode select at rising clock
// - power-up enters test-logic-reset without test clock
// - five mode-select-high clocks force reset
// - controller derives all test control signals
// - bypass, identification and boundary data registers
// - bypass selected when no other register needed
// - 32-bit identification register with four fields
// - boundary cells observe and control every pin
package bstap_pkg;
  // ==========================================
  // sizes
  localparam int IR_W = 4;              // instruction register width
  localparam int ID_W = 32;             // identification register width
  localparam int NPIN = 8;              // user pins covered by boundary cells
  localparam int CELL_W = 3; // cells per pin: input, output and enable
  localparam int CELL_IN = 0; // cell observing the pad level
  localparam int CELL_OUT = 1; // cell controlling the pad value
  localparam int CELL_OE = 2; // cell controlling the pad enable
  localparam int BSR_W = CELL_W * NPIN; // whole boundary chain
  // ==========================================
  // instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'he;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
  localparam logic [1:0] IR_CAPTURE = 2'h1; // fixed capture pattern, low bits
  // ==========================================
  // identification fields; values arbitrary, naming no maker or part
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0a5c;
  localparam logic [10:0] ID_NUMBER = 11'h123;
  localparam logic ID_LSB = 1'b1;       // always one by the scan convention
  // ==========================================
  // controller states, four-bit held
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR,
    ST_EX2_IR, ST_UP_IR
  } bstap_state_t;
  // ==========================================
  // the three test inputs; tdo leaves by its own port
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstap_pins_t;
  // pin bundle for the boundary
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
  } bstap_pad_t;
endpackage

//--- bstap_sync.sv
// two-flop synchroniser for the test pins
`timescale 1ns/100ps
module bstap_sync (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire bstap_pkg::bstap_pins_t i_async,
  output bstap_pkg::bstap_pins_t o_sync
);
  import bstap_pkg::*;
  // ==========================================
  // stage registers
  bstap_pins_t meta_reg; // first stage, read only by the second
  bstap_pins_t sync_reg; // second stage, safe to use
  bstap_pins_t meta_next;
  bstap_pins_t sync_next;

  // next values
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
    if (!i_nrst) begin
      meta_next = '0;
      sync_next = '0;
    end
  end

  // registering only
  always_ff @(posedge i_ref_clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign o_sync = sync_reg;
endmodule

//--- bstap_top.sv
// boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/100ps
module bstap_top (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [bstap_pkg::NPIN-1:0] i_core_out,
  input wire logic [bstap_pkg::NPIN-1:0] i_core_oe,
  input wire logic [bstap_pkg::NPIN-1:0] i_pad_in,
  output logic [bstap_pkg::NPIN-1:0] o_pad_out,
  output logic [bstap_pkg::NPIN-1:0] o_pad_oe,
  output logic [bstap_pkg::NPIN-1:0] o_core_in,
  output logic [3:0] o_state
);
  import bstap_pkg::*;
  // the whole block runs on the reference clock; the test clock is only a
  // level whose edges are found by sampling, trading top speed for one clock
  // ==========================================
  // pin sampling
  bstap_pins_t pins_raw; // unsynchronised test pins
  bstap_pins_t pins; // synchronised test pins
  logic [NPIN-1:0] pad_meta_reg; // pad sampler first stage
  logic [NPIN-1:0] pad_sync_reg; // pad sampler second stage
  logic [NPIN-1:0] pad_meta_next; // first pad stage, next value
  logic [NPIN-1:0] pad_sync_next; // second pad stage, next value
  logic tck_d_reg; // previous synced test clock
  logic tck_d_next; // its next value
  logic rise; // rising test clock edge seen
  logic fall; // falling test clock edge seen

  // tdo is the one test pin driven, so it is not in the input bundle
  // only these three pins reach the test logic
  assign pins_raw = '{tck: i_tck, tms: i_tms, tdi: i_tdi};

  bstap_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // edge finding on the sampled test clock
  assign rise = pins.tck & ~tck_d_reg;
  assign fall = ~pins.tck & tck_d_reg;
  // limitation: the test clock must stay high and low for at least two
  // reference cycles each, or an edge is lost

  // pads are off-chip levels, so two stages before any logic reads them
  always_comb begin
    pad_meta_next = i_pad_in;
    pad_sync_next = pad_meta_reg;
    tck_d_next = pins.tck;
    // history cleared with the sync flops, so no false edge follows reset
    if (!i_nrst) begin
      tck_d_next = 1'b0;
    end
  end

  // registering only
  always_ff @(posedge i_ref_clk) begin
    pad_meta_reg <= pad_meta_next;
    pad_sync_reg <= pad_sync_next;
    tck_d_reg <= tck_d_next;
  end

  // ==========================================
  // controller state
  bstap_state_t st_reg; // controller state
  bstap_state_t st_next;

  // state moves about three reference cycles after the pin rises
  // state graph, moved only on rising test clock
  always_comb begin
    st_next = st_reg;
    if (rise) begin
      case (st_reg)
        ST_RESET: st_next = pins.tms ? ST_RESET : ST_IDLE;
        ST_IDLE: st_next = pins.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: st_next = pins.tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_next = pins.tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: st_next = pins.tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_next = pins.tms ? ST_UP_DR : ST_PA_DR;
        ST_PA_DR: st_next = pins.tms ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: st_next = pins.tms ? ST_UP_DR : ST_SH_DR;
        ST_UP_DR: st_next = pins.tms ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: st_next = pins.tms ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: st_next = pins.tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: st_next = pins.tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_next = pins.tms ? ST_UP_IR : ST_PA_IR;
        ST_PA_IR: st_next = pins.tms ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: st_next = pins.tms ? ST_UP_IR : ST_SH_IR;
        ST_UP_IR: st_next = pins.tms ? ST_SEL_DR : ST_IDLE;
        default: st_next = ST_RESET;
      endcase
    end
    // synchronous power-up reset needs no test clock
    if (!i_nrst) st_next = ST_RESET;
  end

  // registering only
  always_ff @(posedge i_ref_clk) begin
    st_reg <= st_next;
  end

  // ==========================================
  // instruction and data registers
  logic [IR_W-1:0] ir_sh_reg, ir_sh_next; // instruction shift stage
  logic [IR_W-1:0] ir_reg, ir_next; // active instruction
  logic byp_reg, byp_next; // one-bit bypass
  logic [ID_W-1:0] id_reg, id_next; // identification shifter
  logic [BSR_W-1:0] bs_reg, bs_next; // boundary shift stage
  logic [BSR_W-1:0] bs_up_reg, bs_up_next; // boundary update stage
  logic tdo_reg, tdo_next; // serial out, changes on falling edge
  logic tdo_oe_reg, tdo_oe_next; // serial out drive
  logic [ID_W-1:0] id_value; // fixed identification word
  logic [BSR_W-1:0] bs_capture; // boundary capture word
  logic sel_bs; // boundary register chosen
  logic sel_id; // identification register chosen
  logic dr_out; // selected data register output bit
  logic extest_on; // update cells drive the pads

  // four identification fields
  assign id_value = {ID_VERSION, ID_PART, ID_NUMBER, ID_LSB};
  // extest and sample/preload use the boundary, idcode the id, rest bypass
  assign sel_bs = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE);
  assign sel_id = (ir_reg == INS_IDCODE);
  assign dr_out = sel_bs ? bs_reg[0] : (sel_id ? id_reg[0] : byp_reg);

  // per pin three cells: pad in, core out, core enable
  // the update cells reach the pads only under extest, so sample/preload
  // can stage values without disturbing normal pin operation
  assign extest_on = (ir_reg == INS_EXTEST);
  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_cell
      assign bs_capture[CELL_W*p+CELL_IN] = pad_sync_reg[p];
      assign bs_capture[CELL_W*p+CELL_OUT] = i_core_out[p];
      assign bs_capture[CELL_W*p+CELL_OE] = i_core_oe[p];
      // extest drives pads from update cells, else core passes through
      assign o_pad_out[p] = extest_on ? bs_up_reg[CELL_W*p+CELL_OUT] : i_core_out[p];
      assign o_pad_oe[p] = extest_on ? bs_up_reg[CELL_W*p+CELL_OE] : i_core_oe[p];
      assign o_core_in[p] = pad_sync_reg[p];
    end
  endgenerate

  // register next values
  always_comb begin
    ir_sh_next = ir_sh_reg;
    ir_next = ir_reg;
    byp_next = byp_reg;
    id_next = id_reg;
    bs_next = bs_reg;
    bs_up_next = bs_up_reg;
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    // capture, shift and update all act on the sampled rising test clock
    if (rise) begin
      case (st_reg)
        ST_CAP_IR: ir_sh_next = {{(IR_W-2){1'b0}}, IR_CAPTURE};
        ST_SH_IR: ir_sh_next = {pins.tdi, ir_sh_reg[IR_W-1:1]};
        ST_UP_IR: ir_next = ir_sh_reg;
        ST_CAP_DR: begin
          byp_next = 1'b0;
          id_next = id_value;
          if (sel_bs) bs_next = bs_capture;
        end
        ST_SH_DR: begin
          // only the chosen register shifts
          if (sel_bs) bs_next = {pins.tdi, bs_reg[BSR_W-1:1]};
          else if (sel_id) id_next = {pins.tdi, id_reg[ID_W-1:1]};
          else byp_next = pins.tdi;
        end
        ST_UP_DR: if (sel_bs) bs_up_next = bs_reg;
        default: ;
      endcase
    end
    // output changes on falling edge, driven only in shift states
    if (fall) begin
      tdo_oe_next = (st_reg == ST_SH_DR) || (st_reg == ST_SH_IR);
      tdo_next = (st_reg == ST_SH_IR) ? ir_sh_reg[0] : dr_out;
    end
    // test-logic-reset: idcode loaded, boundary transparent
    if (st_reg == ST_RESET) begin
      ir_next = INS_IDCODE;
      tdo_oe_next = 1'b0;
    end
    // power-up reset clears every shift stage and the boundary update stage, and loads idcode
    if (!i_nrst) begin
      ir_sh_next = '0;
      ir_next = INS_IDCODE;
      byp_next = 1'b0;
      id_next = '0;
      bs_next = '0;
      bs_up_next = '0;
      tdo_next = 1'b0;
      tdo_oe_next = 1'b0;
    end
  end

  // registering only; the update stage is apart from the shift stage so
  // pads under extest hold still while new values shift through
  always_ff @(posedge i_ref_clk) begin
    ir_sh_reg <= ir_sh_next;
    ir_reg <= ir_next;
    byp_reg <= byp_next;
    id_reg <= id_next;
    bs_reg <= bs_next;
    bs_up_reg <= bs_up_next;
    tdo_reg <= tdo_next;
    tdo_oe_reg <= tdo_oe_next;
  end

  // ==========================================
  // outputs
  // serial out and its drive are registers, so the pin never glitches
  assign o_tdo = tdo_reg;
  assign o_tdo_oe = tdo_oe_reg;
  assign o_state = st_reg;
endmodule

//--- bstap_top_asserts.sv
// pin-level checks on the boundary-scan access port
`timescale 1ns/100ps
module bstap_top_asserts import bstap_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_tck,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [NPIN-1:0] i_core_out,
  input wire logic [NPIN-1:0] i_core_oe,
  input wire logic [NPIN-1:0] o_pad_out,
  input wire logic [NPIN-1:0] o_pad_oe,
  input wire logic [3:0] o_state
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // ref cycles the test clock has been high; saturates
  logic [3:0] hi_cnt_reg, hi_cnt_next;
  always_comb begin
    hi_cnt_next = 4'h0;
    if (i_tck) hi_cnt_next = (hi_cnt_reg == 4'hf) ? hi_cnt_reg : hi_cnt_reg + 4'h1;
  end
  always_ff @(posedge i_ref_clk) begin
    hi_cnt_reg <= hi_cnt_next;
  end
  // ==========================================
  // controller left state st this cycle
  sequence s_left(int st);
    $changed(o_state) && $past(o_state) == st;
  endsequence
  sequence s_in_reset;
    o_state == 4'h0 [*2];
  endsequence
  a_reset_state: assert property (disable iff (1'b0)
    !i_nrst |=> o_state == 4'h0 && !o_tdo_oe)
    else $error("state not reset");
  a_oe_shift: assert property (o_tdo_oe |-> o_state inside {4'h4, 4'h5, 4'hb, 4'hc})
    else $error("tdo driven outside shift");
  a_state_rise: assert property ($changed(o_state) |-> hi_cnt_reg inside {[1:7]})
    else $error("state moved off a test clock rise");
  a_reset_exit: assert property (s_left(0) |-> o_state == 4'h1)
    else $error("bad exit from reset");
  a_idle_exit: assert property (s_left(1) |-> o_state == 4'h2)
    else $error("bad exit from idle");
  a_select_exit: assert property (s_left(2) |-> o_state inside {4'h3, 4'h9})
    else $error("bad exit from data select");
  a_update_exit: assert property (s_left(8) or s_left(15) |-> o_state inside {4'h1, 4'h2})
    else $error("bad exit from update");
  a_tdo_fall: assert property ($changed(o_tdo) |-> !i_tck)
    else $error("tdo changed while test clock high");
  a_pads_follow: assert property (s_in_reset |->
    o_pad_out == i_core_out && o_pad_oe == i_core_oe)
    else $error("pins disturbed in reset");
endmodule
bind bstap_top bstap_top_asserts u_chk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_tck(i_tck),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
  .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_state(o_state));

//--- bstap_top_tb.sv
// self-checking bench for the boundary-scan access port
`timescale 1ns/100ps
module bstap_top_tb;
  import bstap_pkg::*;
  // next-state nibble per state, for mode select high and low
  localparam logic [63:0] NX1 = 64'h2fefcc0287855920;
  localparam logic [63:0] NX0 = 64'h1bddbba146644311;
  localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_NUMBER, ID_LSB};
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  wire logic tck, tms, tdi;
  logic tdo, tdo_oe, q;
  logic [NPIN-1:0] core_out = '0, core_oe = '0, pad_in = '0, pad_out, pad_oe, core_in, eout, eoe;
  logic [3:0] state;
  logic [31:0] got, d, bexp;
  logic [3:0] codes [3] = '{INS_BYPASS, 4'h5, INS_IDCODE};
  int ms = 0, mismatches = 0, num_checks = 0, cycles = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  bstap_ctl_model ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  bstap_top DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_core_out(core_out), .i_core_oe(core_oe),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_core_in(core_in),
    .o_state(state));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one clock through the model, controller state tracked alongside
  task automatic step(input logic m, input logic di, output logic qo);
    int prev;
    prev = ms;
    ctl.step(m, di, qo);
    ms = m ? NX1[ms*4 +: 4] : NX0[ms*4 +: 4];
    check(32'(state), ms);
    check(32'(tdo_oe), prev == 4 || prev == 11);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    repeat (2) step(1'b0, 1'b0, q);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // hang guard, well above the expected few thousand cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h00e6));
    repeat (4) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    check(32'(state), 0);
    // keep every test clock edge clear of both reference clock edges
    #1;
    for (int i = 0; i < 80; i++) step(1'($urandom), 1'($urandom), q);
    repeat (5) step(1'b1, 1'b0, q);
    check(32'(state), 0);
    step(1'b0, 1'b0, q);
    scan(1'b0, 32, $urandom, got);
    check(got, ID_WORD);
    $display("test walk, reset and identification done");
    foreach (codes[k]) begin
      scan(1'b1, 4, 32'(codes[k]), got);
      check(got, 32'h1);
      d = $urandom;
      scan(1'b0, 32, d, got);
      check(got, codes[k] == INS_IDCODE ? ID_WORD : {d[30:0], 1'b0});
    end
    $display("test instruction codes done");
    @(negedge i_ref_clk);
    {core_out, core_oe, pad_in} = 24'($urandom);
    d = $urandom;
    bexp = '0;
    #1;
    scan(1'b1, 4, 32'(INS_SAMPLE), got);
    scan(1'b0, 24, d, got);
    for (int p = 0; p < NPIN; p++) begin
      bexp[3*p +: 3] = {core_oe[p], core_out[p], pad_in[p]};
      {eoe[p], eout[p]} = d[3*p+1 +: 2];
    end
    check(got, bexp);
    check(32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
    check(32'(core_in), 32'(pad_in));
    scan(1'b1, 4, 32'(INS_EXTEST), got);
    check(32'({pad_oe, pad_out}), 32'({eoe, eout}));
    repeat (5) step(1'b1, 1'b0, q);
    repeat (3) @(negedge i_ref_clk);
    check(32'({pad_oe, pad_out}), 32'({core_oe, core_out}));
    $display("test boundary cells done");
    conclude();
  end
endmodule
